/* shared/itc_pkg.sv */
// Purpose: constants for the interrupt and trap controller
// Assumes: apb slave, 32-bit data, 12-bit byte address
// Notes:   vector locations are trap number times four
package itc_pkg;
    localparam int          NSRC          = 27;      // interrupt nodes
    localparam int          NCH           = 8;       // event transfer channels
    localparam int          NTRAP         = 8;       // hardware trap flags
    localparam int          RESP_MIN_CLK  = 5;       // least response, cpu clocks
    localparam int          RESP_MAX_CLK  = 12;      // longest response, cpu clocks
    localparam logic [3:0]  HOLD_LAST     = 4'(RESP_MIN_CLK - 2);
    // register byte offsets
    localparam logic [11:0] SRC_BASE      = 12'h000; // node control, one word each
    localparam logic [11:0] PCTL_BASE     = 12'h080; // channel control
    localparam logic [11:0] PSRC_BASE     = 12'h0a0; // channel source pointer
    localparam logic [11:0] PDST_BASE     = 12'h0c0; // channel destination pointer
    localparam logic [11:0] TFLAG_ADDR    = 12'h100; // trap flags, write one to clear
    localparam logic [11:0] EDGE_ADDR     = 12'h104; // fast input edge modes
    localparam logic [11:0] STAT_ADDR     = 12'h108; // controller state
    // node control fields
    localparam int          SRC_LVL_LSB   = 0;
    localparam int          SRC_EN_BIT    = 6;
    localparam int          SRC_REQ_BIT   = 7;
    localparam int          SRC_PEC_BIT   = 8;
    localparam int          SRC_CH_LSB    = 9;
    // channel control fields
    localparam int          PCTL_CNT_LSB  = 0;
    localparam int          PCTL_WORD_BIT = 8;
    localparam int          PCTL_CONT_BIT = 9;
    localparam int          PCTL_DST_BIT  = 10;
    // edge mode codes, two bits per fast input
    localparam logic [1:0]  EDGE_RISE     = 2'h1;
    localparam logic [1:0]  EDGE_FALL     = 2'h2;
    localparam logic [1:0]  EDGE_BOTH     = 2'h3;
    // hardware trap numbers and classes
    localparam logic [6:0]  TN_RESET      = 7'h00;
    localparam logic [6:0]  TN_NONMASK    = 7'h02;
    localparam logic [6:0]  TN_STK_OVER   = 7'h04;
    localparam logic [6:0]  TN_STK_UNDER  = 7'h06;
    localparam logic [6:0]  TN_CLASS_B    = 7'h0a;
    localparam logic [1:0]  CLS_RESET     = 2'h3;
    localparam logic [1:0]  CLS_A         = 2'h2;
    localparam logic [1:0]  CLS_B         = 2'h1;
    // trap number of each node, index order of the request vector
    localparam logic [6:0]  SRC_TRAP [0:NSRC-1] = '{
        7'h18, 7'h19, 7'h1a, 7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h1f,
        7'h22, 7'h23, 7'h24, 7'h25, 7'h26, 7'h27, 7'h28, 7'h29,
        7'h2a, 7'h47, 7'h2b, 7'h2c, 7'h2d, 7'h2e, 7'h2f,
        7'h40, 7'h41, 7'h42, 7'h43};
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_HOLD = 2'h1, ST_ISSUE = 2'h3} itc_state_e;
    typedef enum logic [1:0] {K_SRC = 2'h0, K_HW = 2'h1, K_SW = 2'h2} itc_kind_e;
endpackage

/* src/itc_top.sv */
// Purpose: priority interrupt, event transfer and trap controller
// Assumes: cpu reports its level and any trap class in service
// Notes:   one apb slave, zero wait states, registered answers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module itc_top (
    input  wire logic        I_CLK_SYS,
    input  wire logic        I_SYS_RST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [11:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    output logic             O_PREADY,
    output logic [31:0]      O_PRDATA,
    output logic             O_PSLVERR,
    input  wire logic [7:0]  I_EXT_PIN,
    input  wire logic [18:0] I_PERIPH_EVT,
    input  wire logic        I_RESET_EVT,
    input  wire logic [7:0]  I_TRAP_EVT,
    input  wire logic        I_SWTRAP_REQ,
    input  wire logic [6:0]  I_SWTRAP_NUM,
    input  wire logic [3:0]  I_CPU_LEVEL,
    input  wire logic [1:0]  I_TRAP_CLASS,
    input  wire logic        I_VEC_ACK,
    output logic             O_VEC_REQ,
    output logic [15:0]      O_VEC_ADDR,
    output logic [6:0]       O_TRAP_NUM,
    output logic [3:0]       O_VEC_LEVEL,
    output logic             O_VEC_HWTRAP,
    output logic             O_PEC_STB,
    output logic [15:0]      O_PEC_SRC,
    output logic [15:0]      O_PEC_DST,
    output logic             O_PEC_WORD
);
    localparam int NS = itc_pkg::NSRC;
    localparam int NC = itc_pkg::NCH;

    // apb strobes
    logic        wr_en;                // write takes effect this edge
    logic        setup;                // setup phase of a transfer
    logic [31:0] rd_d;                 // read mux
    logic        hit_d;                // address is mapped

    // node state
    logic [3:0]  lvl_q  [NS];          // priority level
    logic [2:0]  ch_q   [NS];          // transfer channel
    logic [NS-1:0] en_q;               // enable flags
    logic [NS-1:0] pec_q;              // event transfer selected
    logic [NS-1:0] req_q;              // request flags
    logic [NS-1:0] evt;                // hardware request events
    logic [NS-1:0] svc_clr;            // service taken

    // channel state
    logic [7:0]  cnt_q  [NC];          // transfer counter
    logic [15:0] sp_q   [NC];          // source pointer
    logic [15:0] dp_q   [NC];          // destination pointer
    logic [NC-1:0] word_q;             // word, else byte
    logic [NC-1:0] cont_q;             // continuous mode
    logic [NC-1:0] incd_q;             // bump destination, else source

    // fast inputs
    logic [7:0]  sync1_q;              // first stage, read by second only
    logic [7:0]  sync2_q;
    logic [7:0]  prev_q;
    logic [15:0] edge_cfg_q;
    logic [7:0]  ext_edge;

    // traps
    logic [7:0]  tflag_q;              // trap flag register
    logic [4:0]  tpend_q;              // reset, nmi, over, under, class b
    logic        sw_pend_q;
    logic [6:0]  sw_num_q;

    // arbitration and sequencing
    itc_pkg::itc_state_e state_q;
    itc_pkg::itc_kind_e  kind_q;
    logic [3:0]  hold_q;
    logic [4:0]  id_q;                 // latched node
    logic [2:0]  tidx_q;               // latched trap pending index
    logic [6:0]  num_q;
    logic [3:0]  lvlo_q;
    logic        best_ok;
    logic [4:0]  best_id;
    logic [3:0]  best_lvl;
    logic        hw_ok;
    logic [2:0]  hw_idx;
    logic [6:0]  hw_num;
    logic [1:0]  hw_cls;
    logic        hold_end;
    logic        pec_fire;
    logic        vec_taken;
    logic [2:0]  lch;

    assign setup     = I_PSEL & ~I_PENABLE;
    assign wr_en     = I_PSEL & I_PENABLE & O_PREADY & I_PWRITE;
    assign hold_end  = (state_q == itc_pkg::ST_HOLD) && (hold_q == itc_pkg::HOLD_LAST);
    assign lch       = ch_q[id_q];
    assign vec_taken = (state_q == itc_pkg::ST_ISSUE) & I_VEC_ACK;
    assign pec_fire  = hold_end & (kind_q == itc_pkg::K_SRC) & pec_q[id_q]
                     & (cont_q[lch] | (cnt_q[lch] != 8'h00));

    // apb answer: data latched in setup, ready in access
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_PREADY  <= 1'b0;
            O_PRDATA  <= 32'h0000_0000;
            O_PSLVERR <= 1'b0;
        end else begin
            O_PREADY  <= setup;
            O_PSLVERR <= setup & ~hit_d;
            if (setup) begin
                O_PRDATA <= rd_d;
            end
        end
    end

    // read mux over all mapped words
    always_comb begin
        rd_d  = 32'h0000_0000;
        hit_d = 1'b0;
        for (int i = 0; i < NS; i++) begin
            if (I_PADDR == itc_pkg::SRC_BASE + 12'(4 * i)) begin
                hit_d = 1'b1;
                rd_d  = {20'h00000, ch_q[i], pec_q[i], req_q[i], en_q[i], 2'h0, lvl_q[i]};
            end
        end
        for (int c = 0; c < NC; c++) begin
            if (I_PADDR == itc_pkg::PCTL_BASE + 12'(4 * c)) begin
                hit_d = 1'b1;
                rd_d  = {21'h000000, incd_q[c], cont_q[c], word_q[c], cnt_q[c]};
            end
            if (I_PADDR == itc_pkg::PSRC_BASE + 12'(4 * c)) begin
                hit_d = 1'b1;
                rd_d  = {16'h0000, sp_q[c]};
            end
            if (I_PADDR == itc_pkg::PDST_BASE + 12'(4 * c)) begin
                hit_d = 1'b1;
                rd_d  = {16'h0000, dp_q[c]};
            end
        end
        if (I_PADDR == itc_pkg::TFLAG_ADDR) begin
            hit_d = 1'b1;
            rd_d  = {24'h000000, tflag_q};
        end
        if (I_PADDR == itc_pkg::EDGE_ADDR) begin
            hit_d = 1'b1;
            rd_d  = {16'h0000, edge_cfg_q};
        end
        if (I_PADDR == itc_pkg::STAT_ADDR) begin
            hit_d = 1'b1;
            rd_d  = {20'h00000, sw_pend_q, tpend_q, state_q, id_q[3:0]};
        end
    end

    // fast input synchroniser and edge detect
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            sync1_q <= 8'h00;
            sync2_q <= 8'h00;
            prev_q  <= 8'h00;
        end else begin
            sync1_q <= I_EXT_PIN;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // edge mode register
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            edge_cfg_q <= 16'h0000;
        end else if (wr_en && I_PADDR == itc_pkg::EDGE_ADDR) begin
            edge_cfg_q <= I_PWDATA[15:0];
        end
    end

    // per node request logic
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_ext
            logic [1:0] md;
            assign md = edge_cfg_q[2*gi +: 2];
            assign ext_edge[gi] = (sync2_q[gi] & ~prev_q[gi] & md[0])
                                | (~sync2_q[gi] & prev_q[gi] & md[1]);
        end
        for (gi = 0; gi < NS; gi++) begin : g_src
            logic hit;
            assign hit = wr_en && (I_PADDR == itc_pkg::SRC_BASE + 12'(4 * gi));
            assign svc_clr[gi] = (id_q == 5'(gi)) & (kind_q == itc_pkg::K_SRC) & (pec_fire | vec_taken);
            always_ff @(posedge I_CLK_SYS) begin
                if (I_SYS_RST) begin
                    lvl_q[gi] <= 4'h0;
                    ch_q[gi]  <= 3'h0;
                    en_q[gi]  <= 1'b0;
                    pec_q[gi] <= 1'b0;
                end else if (hit) begin
                    lvl_q[gi] <= I_PWDATA[itc_pkg::SRC_LVL_LSB +: 4];
                    en_q[gi]  <= I_PWDATA[itc_pkg::SRC_EN_BIT];
                    pec_q[gi] <= I_PWDATA[itc_pkg::SRC_PEC_BIT];
                    ch_q[gi]  <= I_PWDATA[itc_pkg::SRC_CH_LSB +: 3];
                end
            end
            // software set; event set beats any clear
            always_ff @(posedge I_CLK_SYS) begin
                if (I_SYS_RST) begin
                    req_q[gi] <= 1'b0;
                end else if (evt[gi] | (hit & I_PWDATA[itc_pkg::SRC_REQ_BIT])) begin
                    req_q[gi] <= 1'b1;
                end else if (svc_clr[gi] | (hit & ~I_PWDATA[itc_pkg::SRC_REQ_BIT])) begin
                    req_q[gi] <= 1'b0;
                end
            end
        end
    endgenerate
    assign evt = {I_PERIPH_EVT, ext_edge};

    generate
        for (gi = 0; gi < NC; gi++) begin : g_ch
            logic fire;
            assign fire = pec_fire & (lch == 3'(gi));
            always_ff @(posedge I_CLK_SYS) begin
                if (I_SYS_RST) begin
                    cnt_q[gi]  <= 8'h00;
                    word_q[gi] <= 1'b0;
                    cont_q[gi] <= 1'b0;
                    incd_q[gi] <= 1'b0;
                    sp_q[gi]   <= 16'h0000;
                    dp_q[gi]   <= 16'h0000;
                end else begin
                    if (wr_en && I_PADDR == itc_pkg::PCTL_BASE + 12'(4 * gi)) begin
                        cnt_q[gi]  <= I_PWDATA[itc_pkg::PCTL_CNT_LSB +: 8];
                        word_q[gi] <= I_PWDATA[itc_pkg::PCTL_WORD_BIT];
                        cont_q[gi] <= I_PWDATA[itc_pkg::PCTL_CONT_BIT];
                        incd_q[gi] <= I_PWDATA[itc_pkg::PCTL_DST_BIT];
                    end else if (fire && !cont_q[gi]) begin
                        cnt_q[gi] <= cnt_q[gi] - 8'h01;
                    end
                    if (wr_en && I_PADDR == itc_pkg::PSRC_BASE + 12'(4 * gi)) begin
                        sp_q[gi] <= I_PWDATA[15:0];
                    end else if (fire && !incd_q[gi]) begin
                        sp_q[gi] <= sp_q[gi] + {14'h0000, word_q[gi], ~word_q[gi]};
                    end
                    if (wr_en && I_PADDR == itc_pkg::PDST_BASE + 12'(4 * gi)) begin
                        dp_q[gi] <= I_PWDATA[15:0];
                    end else if (fire && incd_q[gi]) begin
                        dp_q[gi] <= dp_q[gi] + {14'h0000, word_q[gi], ~word_q[gi]};
                    end
                end
            end
        end
    endgenerate

    // trap flags: set wins over write-one clear
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            tflag_q <= 8'h00;
        end else begin
            tflag_q <= I_TRAP_EVT
                     | (tflag_q & ~((wr_en && I_PADDR == itc_pkg::TFLAG_ADDR) ? I_PWDATA[7:0] : 8'h00));
        end
    end

    // trap pending bits; reset vector pending after reset
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            tpend_q <= 5'h01;
        end else begin
            for (int t = 0; t < 5; t++) begin
                if (vec_taken && kind_q == itc_pkg::K_HW && tidx_q == 3'(t)) begin
                    tpend_q[t] <= 1'b0;
                end
            end
            if (I_RESET_EVT) begin
                tpend_q[0] <= 1'b1;
            end
            if (I_TRAP_EVT[0]) begin
                tpend_q[1] <= 1'b1;
            end
            if (I_TRAP_EVT[1]) begin
                tpend_q[2] <= 1'b1;
            end
            if (I_TRAP_EVT[2]) begin
                tpend_q[3] <= 1'b1;
            end
            // all class b on one vector
            if (|I_TRAP_EVT[7:3]) begin
                tpend_q[4] <= 1'b1;
            end
        end
    end

    // software trap capture from the cpu
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            sw_pend_q <= 1'b0;
            sw_num_q  <= 7'h00;
        end else if (I_SWTRAP_REQ) begin
            sw_pend_q <= 1'b1;
            sw_num_q  <= I_SWTRAP_NUM;
        end else if (vec_taken && kind_q == itc_pkg::K_SW) begin
            sw_pend_q <= 1'b0;
        end
    end

    // hardware trap pick, highest class first
    // reserved numbers never picked
    always_comb begin
        hw_idx = 3'h4;
        hw_num = itc_pkg::TN_CLASS_B;
        hw_cls = tpend_q[4] ? itc_pkg::CLS_B : 2'h0;
        if (tpend_q[3]) begin
            hw_idx = 3'h3;
            hw_num = itc_pkg::TN_STK_UNDER;
            hw_cls = itc_pkg::CLS_A;
        end
        if (tpend_q[2]) begin
            hw_idx = 3'h2;
            hw_num = itc_pkg::TN_STK_OVER;
            hw_cls = itc_pkg::CLS_A;
        end
        if (tpend_q[1]) begin
            hw_idx = 3'h1;
            hw_num = itc_pkg::TN_NONMASK;
            hw_cls = itc_pkg::CLS_A;
        end
        if (tpend_q[0]) begin
            hw_idx = 3'h0;
            hw_num = itc_pkg::TN_RESET;
            hw_cls = itc_pkg::CLS_RESET;
        end
        // wait for a trap of equal or higher class in service
        hw_ok = hw_cls > I_TRAP_CLASS;
    end

    // node arbitration; ties go to the lower index
    always_comb begin
        best_ok  = 1'b0;
        best_id  = 5'h00;
        best_lvl = I_CPU_LEVEL;
        for (int i = 0; i < NS; i++) begin
            if (req_q[i] && en_q[i] && lvl_q[i] > best_lvl) begin
                best_ok  = 1'b1;
                best_id  = 5'(i);
                best_lvl = lvl_q[i];
            end
        end
    end

    // sequencer: pick, hold to the response time, then answer
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            state_q <= itc_pkg::ST_IDLE;
            kind_q  <= itc_pkg::K_SRC;
            hold_q  <= 4'h0;
            id_q    <= 5'h00;
            tidx_q  <= 3'h0;
            num_q   <= 7'h00;
            lvlo_q  <= 4'h0;
        end else begin
            unique case (state_q)
                itc_pkg::ST_IDLE: begin
                    hold_q <= 4'h0;
                    // traps ahead of all else, no mask
                    if (hw_ok) begin
                        state_q <= itc_pkg::ST_HOLD;
                        kind_q  <= itc_pkg::K_HW;
                        tidx_q  <= hw_idx;
                        num_q   <= hw_num;
                        lvlo_q  <= 4'hf;
                    end else if (sw_pend_q) begin
                        state_q <= itc_pkg::ST_HOLD;
                        kind_q  <= itc_pkg::K_SW;
                        num_q   <= sw_num_q;
                        lvlo_q  <= I_CPU_LEVEL;
                    end else if (best_ok && I_TRAP_CLASS == 2'h0) begin
                        state_q <= itc_pkg::ST_HOLD;
                        kind_q  <= itc_pkg::K_SRC;
                        id_q    <= best_id;
                        num_q   <= itc_pkg::SRC_TRAP[best_id];
                        lvlo_q  <= best_lvl;
                    end
                end
                itc_pkg::ST_HOLD: begin
                    // fixed wait keeps response in range
                    hold_q <= hold_q + 4'h1;
                    if (hold_end) begin
                        // transfer returns to idle, no vector
                        state_q <= pec_fire ? itc_pkg::ST_IDLE : itc_pkg::ST_ISSUE;
                    end
                end
                itc_pkg::ST_ISSUE: begin
                    if (I_VEC_ACK) begin
                        state_q <= itc_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= itc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // vector request outputs, held until the cpu accepts
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_VEC_REQ    <= 1'b0;
            O_VEC_ADDR   <= 16'h0000;
            O_TRAP_NUM   <= 7'h00;
            O_VEC_LEVEL  <= 4'h0;
            O_VEC_HWTRAP <= 1'b0;
        end else if (hold_end && !pec_fire) begin
            O_VEC_REQ    <= 1'b1;
            O_VEC_ADDR   <= {7'h00, num_q, 2'h0};
            O_TRAP_NUM   <= num_q;
            O_VEC_LEVEL  <= lvlo_q;
            O_VEC_HWTRAP <= (kind_q == itc_pkg::K_HW);
        end else if (vec_taken) begin
            O_VEC_REQ    <= 1'b0;
        end
    end

    // single stolen-cycle transfer strobe
    always_ff @(posedge I_CLK_SYS) begin
        if (I_SYS_RST) begin
            O_PEC_STB  <= 1'b0;
            O_PEC_SRC  <= 16'h0000;
            O_PEC_DST  <= 16'h0000;
            O_PEC_WORD <= 1'b0;
        end else begin
            O_PEC_STB <= pec_fire;
            if (pec_fire) begin
                O_PEC_SRC  <= sp_q[lch];
                O_PEC_DST  <= dp_q[lch];
                O_PEC_WORD <= word_q[lch];
            end
        end
    end
endmodule

/* verif/itc_assertions.sv */
// Purpose: checks on the vector and transfer outputs
// Assumes: bound into itc_top, one clock domain
// Notes:   trap response bound holds only from an idle controller
`timescale 1ns/1ps
module itc_assertions (
    input wire logic        I_CLK_SYS,
    input wire logic        I_SYS_RST,
    input wire logic        I_VEC_ACK,
    input wire logic [7:0]  I_TRAP_EVT,
    input wire logic [1:0]  I_TRAP_CLASS,
    input wire logic        O_VEC_REQ,
    input wire logic [15:0] O_VEC_ADDR,
    input wire logic [6:0]  O_TRAP_NUM,
    input wire logic [3:0]  O_VEC_LEVEL,
    input wire logic        O_VEC_HWTRAP,
    input wire logic        O_PEC_STB
);
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (I_SYS_RST);
    // trap seen while nothing is offered
    sequence trap_seen;
        I_TRAP_EVT != 8'h00 && !O_VEC_REQ && I_TRAP_CLASS == 2'h0;
    endsequence
    sequence waiting;
        O_VEC_REQ && !I_VEC_ACK;
    endsequence
    resp_time_a: assert property (trap_seen |-> ##[5:12] O_VEC_REQ) else $error("late vector");
    vec_hold_a: assert property (waiting |=> O_VEC_REQ && $stable(O_VEC_ADDR)) else $error("vector dropped");
    vec_drop_a: assert property (O_VEC_REQ && I_VEC_ACK |=> !O_VEC_REQ) else $error("vector kept");
    vec_addr_a: assert property (O_VEC_REQ |-> O_VEC_ADDR == {7'h00, O_TRAP_NUM, 2'h0}) else $error("bad addr");
    pec_pulse_a: assert property (O_PEC_STB |=> !O_PEC_STB) else $error("long strobe");
    pec_novec_a: assert property (O_PEC_STB |-> !O_VEC_REQ) else $error("strobe with vector");
    hw_level_a: assert property (O_VEC_REQ && O_VEC_HWTRAP |-> O_VEC_LEVEL == 4'hf) else $error("trap level");
    hw_number_a: assert property (O_VEC_REQ && O_VEC_HWTRAP |-> O_TRAP_NUM inside {7'h00, 7'h02, 7'h04, 7'h06,
        7'h0a}) else $error("trap number");
endmodule

/* verif/itc_cpu_model.sv */
// Purpose: cpu side that accepts vectors after a set lag
// Assumes: request level holds until acknowledged
// Notes:   acknowledge is a one-cycle pulse
`timescale 1ns/1ps
module itc_cpu_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_req,
    input  wire logic [3:0] i_lag,
    output logic            o_ack
);
    logic [3:0] wait_q;     // cycles the request has waited
    // lag counter, cleared once the pulse has gone out
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_req || o_ack) begin
            wait_q <= 4'h0;
            o_ack  <= 1'b0;
        end else if (wait_q >= i_lag) begin
            o_ack <= 1'b1;
        end else begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule

/* verif/itc_top_bench.sv */
// Purpose: self-checking bench for itc_top
// Assumes: cpu model acknowledges every vector
// Notes:   each scenario sends its events to an idle controller
`timescale 1ns/1ps
module itc_top_bench;
    logic I_CLK_SYS = 0, I_SYS_RST = 1, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, I_RESET_EVT = 0, I_SWTRAP_REQ = 0;
    logic [11:0] I_PADDR = 0;
    logic [31:0] I_PWDATA = 0, O_PRDATA, r;
    logic [18:0] I_PERIPH_EVT = 0;
    logic [7:0]  I_EXT_PIN = 0, I_TRAP_EVT = 0;
    logic [6:0]  I_SWTRAP_NUM = 0, O_TRAP_NUM;
    logic [3:0]  I_CPU_LEVEL = 0, O_VEC_LEVEL, lag = 4'h1;
    logic [1:0]  I_TRAP_CLASS = 0;
    logic [15:0] O_VEC_ADDR, O_PEC_SRC, O_PEC_DST;
    logic I_VEC_ACK, O_PREADY, O_PSLVERR, O_VEC_REQ, O_VEC_HWTRAP, O_PEC_STB, O_PEC_WORD, serr;
    int   err_count = 0, compares = 0, n;
    itc_top DUT (.*);
    itc_cpu_model cpu (.i_clk(I_CLK_SYS), .i_rst(I_SYS_RST), .i_req(O_VEC_REQ), .i_lag(lag), .o_ack(I_VEC_ACK));
    initial forever #4 I_CLK_SYS = ~I_CLK_SYS;
    task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", s, exp, seen);
        end
    endtask
    // one apb transfer, held until ready is sampled
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge I_CLK_SYS);
        {I_PSEL, I_PENABLE, I_PWRITE, I_PADDR, I_PWDATA} <= {2'b10, w, a, d};
        @(posedge I_CLK_SYS);
        I_PENABLE <= 1'b1;
        @(posedge I_CLK_SYS);
        while (O_PREADY !== 1'b1) @(posedge I_CLK_SYS);
        r = O_PRDATA;
        serr = O_PSLVERR;
        {I_PSEL, I_PENABLE} <= 2'b00;
    endtask
    // wait for a vector (0) or a strobe (1), counting edges
    task wt(input bit s);
        n = 0;
        do begin
            @(posedge I_CLK_SYS);
            n++;
        end while ((s ? O_PEC_STB : O_VEC_REQ) !== 1'b1 && n < 40);
    endtask
    // event pulses, sent only once the controller is idle
    task ev(input logic [18:0] p, input logic [7:0] t);
        while (O_VEC_REQ !== 1'b0) @(posedge I_CLK_SYS);
        repeat (3) @(posedge I_CLK_SYS);
        {I_PERIPH_EVT, I_TRAP_EVT} <= {p, t};
        @(posedge I_CLK_SYS);
        {I_PERIPH_EVT, I_TRAP_EVT} <= 27'h0;
    endtask
    task t_nodes;
        apb(1, 12'h020, 32'h45);
        ev(19'h1, 8'h0); wt(0);
        chk("resp", (n - 1) >= 5 && (n - 1) <= 12, 1);
        chk("t2 addr", O_VEC_ADDR, 16'h0088);
        chk("t2 lvl", O_VEC_LEVEL, 4'h5);
        lag <= 4'h6; ev(19'h0, 8'h0); apb(0, 12'h020, 0);
        chk("req clr", r[7], 0);
        apb(1, 12'h024, 32'h47); I_CPU_LEVEL <= 4'h7;
        ev(19'h3, 8'h0); repeat (20) @(posedge I_CLK_SYS);
        chk("no preempt", O_VEC_REQ, 0);
        I_CPU_LEVEL <= 4'h4; wt(0);
        chk("winner", O_VEC_ADDR, 16'h008c);
        I_CPU_LEVEL <= 4'h0; lag <= 4'h1;
    endtask
    task t_pec;
        apb(1, 12'h080, 32'h101); apb(1, 12'h0a0, 32'h100); apb(1, 12'h028, 32'h143);
        ev(19'h4, 8'h0); wt(1);
        chk("src", {O_PEC_SRC, 15'h0, O_PEC_WORD}, 32'h01000001);
        apb(0, 12'h0a0, 0); chk("bump", r, 32'h102);
        apb(0, 12'h080, 0); chk("count", r, 32'h100);
        ev(19'h4, 8'h0); wt(0); chk("zero vec", O_VEC_ADDR, 16'h0090);
        apb(1, 12'h080, 32'h600); ev(19'h4, 8'h0); wt(1);
        chk("dst", {O_PEC_DST, O_PEC_SRC}, 32'h00000102);
        apb(0, 12'h0c0, 0); chk("dst bump", r, 32'h1);
        apb(0, 12'h080, 0); chk("cont", r, 32'h600);
    endtask
    task t_traps;
        for (int i = 0; i < 3; i++) begin
            ev(19'h0, 8'(1 << i)); wt(0);
            chk("class a", O_VEC_ADDR, 16'(8 * (i + 1)));
        end
        ev(19'h0, 8'h08); wt(0);
        chk("class b", {O_VEC_HWTRAP, O_TRAP_NUM, O_VEC_ADDR}, {1'b1, 7'h0a, 16'h0028});
        apb(0, 12'h100, 0); chk("flags", r, 32'h0f);
        apb(1, 12'h100, 32'hff); apb(0, 12'h100, 0); chk("cleared", r, 32'h0);
        apb(0, 12'hffc, 0); chk("unmapped err", serr, 1);
        chk("unmapped data", r, 32'h0);
    endtask
    // pins, software set, and traps against a trap in service
    task t_more;
        apb(1, 12'h104, 32'h1); apb(1, 12'h000, 32'h41); I_EXT_PIN <= 8'h01; wt(0);
        chk("pin rise", O_VEC_ADDR, 16'h0060);
        ev(19'h0, 8'h0); I_EXT_PIN <= 8'h00; repeat (20) @(posedge I_CLK_SYS);
        chk("no fall", O_VEC_REQ, 0);
        apb(1, 12'h068, 32'hc1); wt(0);
        chk("sw set", O_VEC_ADDR, 16'h010c);
        ev(19'h0, 8'h0); I_TRAP_CLASS <= 2'h2; ev(19'h1, 8'h0); repeat (20) @(posedge I_CLK_SYS);
        chk("node held", O_VEC_REQ, 0);
        ev(19'h0, 8'h08); repeat (20) @(posedge I_CLK_SYS);
        chk("trap held", O_VEC_REQ, 0);
        I_TRAP_CLASS <= 2'h0; wt(0);
        chk("trap first", {O_VEC_HWTRAP, O_VEC_ADDR}, {1'b1, 16'h0028});
        ev(19'h0, 8'h0); wt(0);
        chk("node after", O_VEC_ADDR, 16'h0088);
    endtask
    task t_sw;
        ev(19'h0, 8'h0); I_CPU_LEVEL <= 4'h3; {I_SWTRAP_NUM, I_SWTRAP_REQ} <= {7'h7f, 1'b1};
        @(posedge I_CLK_SYS); I_SWTRAP_REQ <= 1'b0; wt(0);
        chk("sw trap", {O_VEC_LEVEL, O_VEC_ADDR}, {4'h3, 16'h01fc});
    endtask
    task end_of_test;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge I_CLK_SYS);
        I_SYS_RST <= 1'b0; wt(0);
        chk("reset vec", {O_VEC_HWTRAP, O_VEC_ADDR}, {1'b1, 16'h0});
        t_nodes; t_pec; t_traps; t_more; t_sw;
        end_of_test;
    end
    initial begin
        #200000 err_count++;
        end_of_test;
    end
endmodule
bind itc_top itc_assertions chk_u (.*);
